// >>> rtl/vrt_cfg.svh
// Constants for the voltage reference and temperature sensor control block
`ifndef VRT_CFG_SVH
`define VRT_CFG_SVH
`define VRT_CTRL_OFS 16'h020C
`define VRT_CALC_ADC_OFS 16'h0210
`define VRT_CALC_GAIN_OFS 16'h0214
`define VRT_CALC_OFFS_OFS 16'h0218
`define VRT_CALC_CMD_OFS 16'h021C
`define VRT_CALC_RES_OFS 16'h0220
`define VRT_EN_BIT 7
`define VRT_RDY_BIT 6
`define VRT_SENSOR_ENABLE_BIT 5
`define VRT_RNG_BIT 4
`define VRT_CTRL_RST 8'h00
`define VRT_WMASK 8'hBF
`define VRT_SETTLE_NS 25000
`define VRT_CLK_NS 10
`define VRT_SETTLE_CYC ((`VRT_SETTLE_NS + `VRT_CLK_NS - 1) / `VRT_CLK_NS)
`define VRT_GAIN_DIV_SH 8
`define VRT_FINAL_DIV 10
`endif

// >>> rtl/vrt_ctrl.sv
// Reference and temperature sensor control register with temperature datapath
//
// Behaviour
// - One 8-bit control register at 0x020C with the six documented fields.
// - Reference enable bit 7, read/write, resets to 0.
// - Ready bit 6 is read-only, 1 only when reference output usable.
// - Ready stays low through a settle interval after enabling.
// - Sensor enable bit 5 switches the temperature indicator, resets to 0.
// - Range select bit 4: 1 high range (3 VT), 0 low range (2 VT).
// - Buffer-2 gain bits 3:2: 11 4x, 10 2x, 01 1x, 00 off.
// - Buffer-1 gain bits 1:0: 11 4x, 10 2x, 01 1x, 00 off.
// - Buffer 2 feeds DAC and comparator, and ADC as input only.
// - Buffer 1 feeds ADC only, as reference and as input channel.
// - Temperature is ((count times gain) / 256 + offset) / 10.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`include "vrt_cfg.svh"
module vrt_ctrl
    import vrt_pkg::*;
#(
    parameter int SETTLE_CYC = `VRT_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output vrt_analog_t analog_q,
    output vrt_gain_t buf2_to_dac_cmp_q,
    output vrt_gain_t buf2_to_adc_chan_q,
    output vrt_gain_t buf1_to_adc_ref_q,
    output vrt_gain_t buf1_to_adc_chan_q,
    output logic ref_ready_q
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic sel_ctrl = (reg_addr == `VRT_CTRL_OFS);
    wire logic sel_adc = (reg_addr == `VRT_CALC_ADC_OFS);
    wire logic sel_gain = (reg_addr == `VRT_CALC_GAIN_OFS);
    wire logic sel_offs = (reg_addr == `VRT_CALC_OFFS_OFS);
    wire logic sel_cmd = (reg_addr == `VRT_CALC_CMD_OFS);
    wire logic sel_res = (reg_addr == `VRT_CALC_RES_OFS);
    wire logic sel_any = sel_ctrl | sel_adc | sel_gain | sel_offs | sel_cmd | sel_res;

    // ------------------------------------------------------------
    // Control register and settle sequencer
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    vrt_state_t state_q;
    vrt_state_t state_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    wire logic en_now = ctrl_q[`VRT_EN_BIT];
    wire logic [7:0] wr_mask = `VRT_WMASK;

    // Ready bit is never stored from a write
    assign ctrl_d = (reg_wr && sel_ctrl) ? (reg_wdata[7:0] & wr_mask) : ctrl_q;

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            VRT_IDLE: begin
                cnt_d = 32'h0;
                if (en_now) begin
                    state_d = VRT_SETTLE;
                end
            end
            VRT_SETTLE: begin
                cnt_d = cnt_q + 32'h1;
                if (!en_now) begin
                    state_d = VRT_IDLE;
                end else if (cnt_q >= 32'(SETTLE_CYC - 1)) begin
                    state_d = VRT_READY;
                end
            end
            VRT_READY: begin
                if (!en_now) begin
                    state_d = VRT_IDLE;
                end
            end
            default: begin
                state_d = VRT_IDLE;
            end
        endcase
    end

    // Register and sequencer flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= `VRT_CTRL_RST;
            state_q <= VRT_IDLE;
            cnt_q <= 32'h0;
        end else begin
            ctrl_q <= ctrl_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Analog controls and routing
    // ------------------------------------------------------------
    wire logic ready_d = (state_d == VRT_READY) && ctrl_d[`VRT_EN_BIT];
    wire vrt_gain_t b2_d = ctrl_d[`VRT_EN_BIT] ? vrt_gain_t'(ctrl_d[3:2]) : VRT_BUF_OFF;
    wire vrt_gain_t b1_d = ctrl_d[`VRT_EN_BIT] ? vrt_gain_t'(ctrl_d[1:0]) : VRT_BUF_OFF;
    vrt_analog_t analog_d;
    assign analog_d.ref_on = ctrl_d[`VRT_EN_BIT];
    assign analog_d.sensor_on = ctrl_d[`VRT_SENSOR_ENABLE_BIT];
    assign analog_d.high_range = ctrl_d[`VRT_RNG_BIT];
    assign analog_d.buf2 = b2_d;
    assign analog_d.buf1 = b1_d;

    // Output flops for the analog side
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            analog_q <= '0;
            ref_ready_q <= 1'b0;
            buf2_to_dac_cmp_q <= VRT_BUF_OFF;
            buf2_to_adc_chan_q <= VRT_BUF_OFF;
            buf1_to_adc_ref_q <= VRT_BUF_OFF;
            buf1_to_adc_chan_q <= VRT_BUF_OFF;
        end else begin
            analog_q <= analog_d;
            ref_ready_q <= ready_d;
            buf2_to_dac_cmp_q <= b2_d;
            buf2_to_adc_chan_q <= b2_d;
            buf1_to_adc_ref_q <= b1_d;
            buf1_to_adc_chan_q <= b1_d;
        end
    end

    // ------------------------------------------------------------
    // Temperature datapath
    // ------------------------------------------------------------
    logic [15:0] adc_q;
    logic signed [15:0] gain_q;
    logic signed [15:0] offs_q;
    logic signed [23:0] res_q;
    logic busy_q;

    // Count from high and low result bytes
    function automatic logic [15:0] vrt_join(input logic [7:0] hi, input logic [7:0] lo);
        vrt_join = 16'(({8'h00, hi} << 8) + {8'h00, lo});
    endfunction : vrt_join

    // Formula in a 24-bit signed accumulator
    function automatic logic signed [23:0] vrt_temp(input logic [15:0] cnt,
            input logic signed [15:0] g, input logic signed [15:0] o);
        logic signed [23:0] acc;
        acc = 24'(signed'({1'b0, cnt}) * g);
        acc = acc / 24'sd256;
        acc = acc + 24'(o);
        vrt_temp = acc / 24'sd10;
    endfunction : vrt_temp

    // Software loads range constants and averaged count, then starts
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adc_q <= 16'h0000;
            gain_q <= 16'sh0000;
            offs_q <= 16'sh0000;
            res_q <= 24'sh000000;
            busy_q <= 1'b0;
        end else begin
            if (reg_wr && sel_adc) begin
                adc_q <= vrt_join(reg_wdata[15:8], reg_wdata[7:0]);
            end
            if (reg_wr && sel_gain) begin
                gain_q <= signed'(reg_wdata);
            end
            if (reg_wr && sel_offs) begin
                offs_q <= signed'(reg_wdata);
            end
            busy_q <= reg_wr && sel_cmd && reg_wdata[0];
            if (busy_q) begin
                res_q <= vrt_temp(adc_q, gain_q, offs_q);
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire logic [7:0] ctrl_view = {ctrl_q[7], ref_ready_q, ctrl_q[5:0]};
    wire logic [15:0] rd_mux = sel_ctrl ? {8'h00, ctrl_view} :
                              sel_adc ? adc_q :
                              sel_gain ? gain_q :
                              sel_offs ? offs_q :
                              sel_cmd ? {15'h0000, busy_q} :
                              sel_res ? res_q[15:0] : 16'h0000;

    // Read data valid the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Cycles the enable bit has stood set, saturating
    logic [31:0] on_cnt_q;
    always_ff @(posedge clk) begin
        if (sys_rst || !ctrl_q[`VRT_EN_BIT]) begin
            on_cnt_q <= 32'h0;
        end else if (on_cnt_q != 32'hFFFF_FFFF) begin
            on_cnt_q <= on_cnt_q + 32'h1;
        end
    end

    // Steps watched by the checks below
    sequence en_rise_s;
        $rose(ctrl_q[`VRT_EN_BIT]);
    endsequence
    sequence off_wr_s;
        reg_wr && sel_ctrl && !reg_wdata[`VRT_EN_BIT];
    endsequence
    sequence adc_wr_s;
        reg_wr && sel_adc;
    endsequence
    rdy_needs_en_a: assert property (@(posedge clk) disable iff (sys_rst)
        ref_ready_q |-> analog_q.ref_on)
        else $error("ready without enable");
    rdy_settle_a: assert property (@(posedge clk) disable iff (sys_rst)
        en_rise_s |-> !ref_ready_q [*2])
        else $error("ready too soon");
    off_buffers_a: assert property (@(posedge clk) disable iff (sys_rst)
        !analog_q.ref_on |-> (analog_q.buf1 == VRT_BUF_OFF && analog_q.buf2 == VRT_BUF_OFF))
        else $error("buffer on while disabled");
    ctrl_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && sel_ctrl) |=> (ctrl_q[7] == $past(reg_wdata[7])))
        else $error("enable write lost");
    rdy_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && sel_ctrl) |=> (ctrl_q[`VRT_RDY_BIT] == 1'b0))
        else $error("ready bit stored");
    sensor_on_a: assert property (@(posedge clk) disable iff (sys_rst)
        analog_q.sensor_on == ctrl_q[`VRT_SENSOR_ENABLE_BIT])
        else $error("sensor enable mismatch");
    range_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
        analog_q.high_range == ctrl_q[`VRT_RNG_BIT])
        else $error("range mismatch");
    buf2_route_a: assert property (@(posedge clk) disable iff (sys_rst)
        (buf2_to_dac_cmp_q == analog_q.buf2) && (buf2_to_adc_chan_q == analog_q.buf2))
        else $error("buffer 2 routing");
    buf1_route_a: assert property (@(posedge clk) disable iff (sys_rst)
        (buf1_to_adc_ref_q == analog_q.buf1) && (buf1_to_adc_chan_q == analog_q.buf1))
        else $error("buffer 1 routing");
    gain2_a: assert property (@(posedge clk) disable iff (sys_rst)
        analog_q.ref_on |-> (analog_q.buf2 == vrt_gain_t'(ctrl_q[3:2])))
        else $error("buffer 2 gain");
    gain1_a: assert property (@(posedge clk) disable iff (sys_rst)
        analog_q.ref_on |-> (analog_q.buf1 == vrt_gain_t'(ctrl_q[1:0])))
        else $error("buffer 1 gain");
    calc_res_a: assert property (@(posedge clk) disable iff (sys_rst)
        busy_q |=> (res_q == vrt_temp($past(adc_q), $past(gain_q), $past(offs_q))))
        else $error("temperature result");
    rd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> (reg_rdata == 16'h0000))
        else $error("read data outside slot");

    // Settle timing, clear on disable, read path and datapath loads
    settle_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        ref_ready_q |-> (on_cnt_q > 32'(SETTLE_CYC)))
        else $error("ready before settle time");
    ready_due_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_q[`VRT_EN_BIT] && (on_cnt_q > 32'(SETTLE_CYC))) |-> ref_ready_q)
        else $error("ready missing after settle time");
    off_now_a: assert property (@(posedge clk) disable iff (sys_rst)
        off_wr_s |=> (!ref_ready_q && !analog_q.ref_on &&
            analog_q.buf1 == VRT_BUF_OFF && analog_q.buf2 == VRT_BUF_OFF))
        else $error("disable not immediate");
    ctrl_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && sel_ctrl) |=>
            (reg_rdata == {8'h00, $past(ctrl_q[7]), $past(ref_ready_q), $past(ctrl_q[5:0])}))
        else $error("control read value");
    unmapped_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && !sel_any) |=> (reg_rdata == 16'h0000))
        else $error("unmapped read not zero");
    adc_join_a: assert property (@(posedge clk) disable iff (sys_rst)
        adc_wr_s |=> (adc_q == {$past(reg_wdata[15:8]), $past(reg_wdata[7:0])}))
        else $error("count bytes joined wrongly");
    gain_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && sel_gain) |=> (gain_q == $past(reg_wdata)))
        else $error("gain not loaded");
    offs_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && sel_offs) |=> (offs_q == $past(reg_wdata)))
        else $error("offset not loaded");
    calc_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && sel_cmd && reg_wdata[0]) |=> busy_q)
        else $error("calculation not started");

endmodule : vrt_ctrl

// >>> rtl/vrt_pkg.sv
// Types for the voltage reference and temperature sensor control block
package vrt_pkg;
    typedef enum logic [1:0] {
        VRT_BUF_OFF = 2'b00,
        VRT_BUF_X1 = 2'b01,
        VRT_BUF_X2 = 2'b10,
        VRT_BUF_X4 = 2'b11
    } vrt_gain_t;
    typedef struct packed {
        logic ref_on;
        logic sensor_on;
        logic high_range;
        vrt_gain_t buf2;
        vrt_gain_t buf1;
    } vrt_analog_t;
    typedef enum logic [1:0] {
        VRT_IDLE = 2'b00,
        VRT_SETTLE = 2'b01,
        VRT_READY = 2'b10
    } vrt_state_t;
endpackage : vrt_pkg

// >>> sim/voltage_ref_temp_sensor_ctrl_bench.sv
// Self-checking bench for the reference and sensor control block
`timescale 1ns/1ns
`include "vrt_cfg.svh"
module voltage_ref_temp_sensor_ctrl_bench
    import vrt_pkg::*;
;
    localparam int SC = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] rv;
    logic rdy;
    logic cok;
    vrt_analog_t an;
    vrt_gain_t b2d, b2a, b1r, b1a;
    integer dmv, rmv, svt;
    int mismatches = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    vrt_ctrl #(.SETTLE_CYC(SC)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .analog_q(an), .buf2_to_dac_cmp_q(b2d), .buf2_to_adc_chan_q(b2a),
        .buf1_to_adc_ref_q(b1r), .buf1_to_adc_chan_q(b1a), .ref_ready_q(rdy));
    vrt_far_side u_far (.analog_q(an), .b2_dac(b2d), .b2_chan(b2a), .b1_ref(b1r),
        .b1_chan(b1a), .dac_mv(dmv), .ref_mv(rmv), .sense_vt(svt), .chan_ok(cok));
    task automatic conclude();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_mv(string nm, integer e, integer g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk_mv
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    // Ready held low through settling, then set
    task automatic t_enable();
        int n;
        wr(`VRT_CTRL_OFS, 16'h0000);
        wr(`VRT_CTRL_OFS, 16'h0080);
        chk("ready", 16'h0000, {15'h0000, rdy});
        for (n = 0; n < SC + 4 && rdy !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (rdy !== 1'b1) begin
            chk("ready timeout", 16'h0001, {15'h0000, rdy});
            conclude();
        end
        chk("settle", 16'(SC + 1), 16'(n));
        rd(`VRT_CTRL_OFS);
        chk("ctrl", 16'h00C0, rv);
    endtask : t_enable
    // Every gain code on both buffers
    task automatic t_gains();
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            wr(`VRT_CTRL_OFS, {12'h008, c});
            chk("b1", {14'h0000, c[1:0]}, {14'h0000, b1r});
            chk("b2", {14'h0000, c[3:2]}, {14'h0000, b2d});
            chk("an", {9'h000, 3'b100, c}, {9'h000, an});
            chk("chan", 16'h0001, {15'h0000, cok});
            chk_mv("dac", c[3:2] == 2'h0 ? 0 : 512 << c[3:2], dmv);
            chk_mv("vref", c[1:0] == 2'h0 ? 0 : 512 << c[1:0], rmv);
            rd(`VRT_CTRL_OFS);
            chk("ctrl", {8'h00, 4'hC, c}, rv);
        end
    endtask : t_gains
    // Disable with ready bit written, then re-enable
    task automatic t_disable();
        wr(`VRT_CTRL_OFS, 16'h004F);
        chk("off", 16'h0000, {an.ref_on, rdy, b1r, b2d, b1a, b2a});
        rd(`VRT_CTRL_OFS);
        chk("ctrl", 16'h000F, rv);
        wr(`VRT_CTRL_OFS, 16'h00CF);
        rd(`VRT_CTRL_OFS);
        chk("ctrl", 16'h008F, rv);
    endtask : t_disable
    // Sensor enable and range
    task automatic t_sensor();
        wr(`VRT_CTRL_OFS, 16'h00B0);
        chk_mv("vt", 3, svt);
        wr(`VRT_CTRL_OFS, 16'h00A0);
        chk_mv("vt", 2, svt);
        wr(`VRT_CTRL_OFS, 16'h0080);
        chk_mv("vt", 0, svt);
    endtask : t_sensor
    // Temperature datapath with signed constants
    task automatic t_calc(logic [15:0] cnt, logic signed [15:0] g, logic signed [15:0] o);
        int e;
        int n;
        int sum;
        sum = 0;
        for (int k = 0; k < 10; k++) sum += int'(cnt) + k - 4;
        e = (((sum / 10) * int'(g)) / 256 + int'(o)) / 10;
        wr(`VRT_CALC_ADC_OFS, 16'(sum / 10));
        wr(`VRT_CALC_GAIN_OFS, g);
        wr(`VRT_CALC_OFFS_OFS, o);
        wr(`VRT_CALC_CMD_OFS, 16'h0001);
        rv = 16'h0001;
        for (n = 0; n < 20 && rv[0] !== 1'b0; n++) rd(`VRT_CALC_CMD_OFS);
        if (n == 20) begin
            chk("busy timeout", 16'h0000, rv);
            conclude();
        end
        rd(`VRT_CALC_RES_OFS);
        chk("temp", e[15:0], rv);
    endtask : t_calc
    // Unmapped place reads 0 and ignores writes
    task automatic t_unmapped();
        rd(16'h0208);
        chk("unmapped", 16'h0000, rv);
        wr(16'h0208, 16'hFFFF);
        rd(`VRT_CTRL_OFS);
        chk("ctrl", 16'h00C0, rv);
    endtask : t_unmapped
    // Reset in mid-run clears every output, the control register and the temperature result
    task automatic t_reset();
        wr(`VRT_CTRL_OFS, 16'h00BF);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk("rst out", 16'h0000, {an, rdy, b1r, b2d, b1a, b2a});
        rd(`VRT_CTRL_OFS);
        chk("rst ctrl", 16'h0000, rv);
        rd(`VRT_CALC_RES_OFS);
        chk("rst temp", 16'h0000, rv);
    endtask : t_reset
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`VRT_CTRL_OFS);
        chk("reset", 16'h0000, rv);
        t_enable();
        t_gains();
        t_disable();
        t_enable();
        t_sensor();
        // Low range constants first, then high range constants
        t_calc(16'h0123, -16'sd1500, 16'sd400);
        t_calc(16'h0A5C, 16'sh0C00, -16'sd250);
        t_unmapped();
        t_reset();
        conclude();
    end
endmodule : voltage_ref_temp_sensor_ctrl_bench

// >>> sim/vrt_far_side.sv
// Analog buffers and temperature indicator seen from the control block
`timescale 1ns/1ns
module vrt_far_side
    import vrt_pkg::*;
(
    input wire vrt_analog_t analog_q,
    input wire vrt_gain_t b2_dac,
    input wire vrt_gain_t b2_chan,
    input wire vrt_gain_t b1_ref,
    input wire vrt_gain_t b1_chan,
    output integer dac_mv,
    output integer ref_mv,
    output integer sense_vt,
    output logic chan_ok
);
    // Buffer level in mV, 0 when off
    function automatic integer lvl(vrt_gain_t g);
        return (g == VRT_BUF_OFF) ? 0 : (512 << g);
    endfunction : lvl
    // Levels at the consumers
    assign dac_mv = lvl(b2_dac);
    assign ref_mv = lvl(b1_ref);
    assign chan_ok = (b2_chan === b2_dac) && (b1_chan === b1_ref);
    // Indicator output in thermal voltages
    assign sense_vt = !analog_q.sensor_on ? 0 : (analog_q.high_range ? 3 : 2);
endmodule : vrt_far_side
